// file: logic/pscr_defines.vh
// Purpose: shared constants of the status/control register bank
// Assumes: 32-bit AXI4-Lite data, 8-bit byte addresses
// Notes: register indices are word indices; byte address is index times four
`ifndef PSCR_DEFINES_VH
`define PSCR_DEFINES_VH

// bus geometry
`define PSCR_ADDR_W 8
`define PSCR_DATA_W 32

// register word indices
`define PSCR_IDX_STATUS 6'h05
`define PSCR_IDX_CONTROL 6'h06
`define PSCR_IDX_EVENT 6'h08
`define PSCR_IDX_MASK 6'h09

// device_status field positions
`define PSCR_ST_SEAL 7
`define PSCR_ST_NVMOD 6
`define PSCR_ST_ADAPTER 5
`define PSCR_ST_BUTTON 4
`define PSCR_ST_PWR_HI 3
`define PSCR_ST_PWR_LO 2
`define PSCR_ST_CELL_HI 1
`define PSCR_ST_CELL_LO 0

// device_control field positions
`define PSCR_CT_ARM 1
`define PSCR_CT_GO 0

// event register bits (event and mask share this layout)
`define PSCR_EV_W 4
`define PSCR_EV_ADAPTER 0
`define PSCR_EV_BUTTON 1
`define PSCR_EV_CELL_DONE 2
`define PSCR_EV_PWRFAIL 3

// reset values
`define PSCR_RST_CONTROL 2'h0
`define PSCR_RST_CELL 2'h0
`define PSCR_RST_EVENT 4'h0
`define PSCR_RST_MASK 4'h0
`define PSCR_RST_PINS 3'h7

// power state codes
`define PSCR_PWR_TRANS 2'h0
`define PSCR_PWR_WAIT_EN 2'h1
`define PSCR_PWR_ACTIVE 2'h2
`define PSCR_PWR_SUSPEND 2'h3

// axi responses
`define PSCR_RESP_OKAY 2'h0
`define PSCR_RESP_DECERR 2'h3

`endif

// file: logic/pscr_sync.v
// Purpose: two-flop synchroniser for a group of pin levels
// Assumes: inputs are asynchronous to i_mclk
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module pscr_sync #(
    parameter WIDTH = 3,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b1}}
) (
    input wire i_mclk,
    input wire i_resetn,
    input wire [WIDTH-1:0] i_async,
    output reg [WIDTH-1:0] o_sync
);

    reg [WIDTH-1:0] meta_q;

    // two stages, synchronous reset to the idle level
    always @(posedge i_mclk) begin
        if (!i_resetn) begin
            meta_q <= RESET_VAL;
            o_sync <= RESET_VAL;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end

endmodule

// file: logic/pscr_regs.v
// Purpose: status and control register bank of the power manager, AXI4-Lite slave
// Assumes: one clock i_mclk at 10 MHz, synchronous active-low reset
// Notes: pins pass a two-flop synchroniser; event bits clear on read of their register
`timescale 1ns/1ps
`include "pscr_defines.vh"

module pscr_regs (
    input wire i_mclk,
    input wire i_resetn,
    // axi4-lite write address
    input wire i_awvalid,
    output reg o_awready,
    input wire [`PSCR_ADDR_W-1:0] i_awaddr,
    input wire [2:0] i_awprot,
    // axi4-lite write data
    input wire i_wvalid,
    output reg o_wready,
    input wire [`PSCR_DATA_W-1:0] i_wdata,
    input wire [3:0] i_wstrb,
    // axi4-lite write response
    output reg o_bvalid,
    input wire i_bready,
    output reg [1:0] o_bresp,
    // axi4-lite read address
    input wire i_arvalid,
    output reg o_arready,
    input wire [`PSCR_ADDR_W-1:0] i_araddr,
    input wire [2:0] i_arprot,
    // axi4-lite read data
    output reg o_rvalid,
    input wire i_rready,
    output reg [`PSCR_DATA_W-1:0] o_rdata,
    output reg [1:0] o_rresp,
    // pins, asynchronous
    input wire i_adapter_detect_pin,
    input wire i_push_button_pin,
    input wire i_powerfail_out_n,
    // levels from on-chip logic on i_mclk
    input wire i_factory_seal_broken,
    input wire i_nv_settings_modified,
    input wire [1:0] i_power_state,
    // coin-cell measurement unit
    input wire i_cell_done,
    input wire [1:0] i_cell_band,
    output reg o_cell_measure_start,
    // power sequencer shutdown request, level
    output reg o_powerfail_shutdown,
    // interrupt, level, active high
    output reg o_irq
);

    // register selects returned by the decoder
    localparam SEL_NONE = 3'd0;
    localparam SEL_STATUS = 3'd1;
    localparam SEL_CONTROL = 3'd2;
    localparam SEL_EVENT = 3'd3;
    localparam SEL_MASK = 3'd4;

    // address decode shared by read and write paths
    function [2:0] pscr_decode;
        input [`PSCR_ADDR_W-1:0] addr;
        begin
            if (addr == {`PSCR_IDX_STATUS, 2'b00}) begin
                pscr_decode = SEL_STATUS;
            end else if (addr == {`PSCR_IDX_CONTROL, 2'b00}) begin
                pscr_decode = SEL_CONTROL;
            end else if (addr == {`PSCR_IDX_EVENT, 2'b00}) begin
                pscr_decode = SEL_EVENT;
            end else if (addr == {`PSCR_IDX_MASK, 2'b00}) begin
                pscr_decode = SEL_MASK;
            end else begin
                pscr_decode = SEL_NONE;
            end
        end
    endfunction

    // synchronised pins: bit 2 adapter, bit 1 button, bit 0 powerfail
    wire [2:0] pins_s;
    reg [2:0] pins_prev_q;

    // control and status state
    reg arm_q;
    reg go_q;
    reg [1:0] cell_band_q;
    reg [`PSCR_EV_W-1:0] event_q;
    reg [`PSCR_EV_W-1:0] event_d;
    reg [`PSCR_EV_W-1:0] mask_q;
    reg [`PSCR_EV_W-1:0] mask_d;
    reg [`PSCR_EV_W-1:0] event_set;
    reg trip_prev_q;

    // write channel holding state
    reg aw_full_q;
    reg w_full_q;
    reg [`PSCR_ADDR_W-1:0] awaddr_q;
    reg [7:0] wbyte_q;
    reg wlane_q;

    // combinational helpers
    wire aw_take;
    wire w_take;
    wire ar_take;
    wire do_write;
    wire [2:0] wsel;
    wire [2:0] rsel;
    wire trip;
    wire [7:0] status_byte;
    wire [7:0] control_byte;
    reg [7:0] read_byte;

    pscr_sync #(
        .WIDTH(3),
        .RESET_VAL(`PSCR_RST_PINS)
    ) u_pin_sync (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_async({i_adapter_detect_pin, i_push_button_pin, i_powerfail_out_n}),
        .o_sync(pins_s)
    );

    // channel handshakes
    assign aw_take = i_awvalid & o_awready;
    assign w_take = i_wvalid & o_wready;
    assign ar_take = i_arvalid & o_arready;
    assign do_write = aw_full_q & w_full_q & ~o_bvalid;
    assign wsel = pscr_decode(awaddr_q);
    assign rsel = pscr_decode(i_araddr);

    // armed shutdown fires while the comparator output is low
    assign trip = arm_q & ~pins_s[0];

    // live status byte
    assign status_byte[`PSCR_ST_SEAL] = i_factory_seal_broken;
    assign status_byte[`PSCR_ST_NVMOD] = i_nv_settings_modified;
    assign status_byte[`PSCR_ST_ADAPTER] = ~pins_s[2];
    assign status_byte[`PSCR_ST_BUTTON] = ~pins_s[1];
    assign status_byte[`PSCR_ST_PWR_HI:`PSCR_ST_PWR_LO] = i_power_state;
    assign status_byte[`PSCR_ST_CELL_HI:`PSCR_ST_CELL_LO] = cell_band_q;

    // upper control bits read as zero
    assign control_byte = {6'h00, arm_q, go_q};

    // read data multiplexer
    always @* begin
        case (rsel)
            SEL_STATUS: begin
                read_byte = status_byte;
            end
            SEL_CONTROL: begin
                read_byte = control_byte;
            end
            SEL_EVENT: begin
                read_byte = {4'h0, event_q};
            end
            SEL_MASK: begin
                read_byte = {4'h0, mask_q};
            end
            default: begin
                read_byte = 8'h00;
            end
        endcase
    end

    // event sources, set wins over the read clear
    always @* begin
        event_set = `PSCR_RST_EVENT;
        event_set[`PSCR_EV_ADAPTER] = pins_s[2] ^ pins_prev_q[2];
        event_set[`PSCR_EV_BUTTON] = pins_s[1] ^ pins_prev_q[1];
        event_set[`PSCR_EV_CELL_DONE] = i_cell_done;
        event_set[`PSCR_EV_PWRFAIL] = trip & ~trip_prev_q;
        event_d = event_q;
        if (ar_take && rsel == SEL_EVENT) begin
            event_d = `PSCR_RST_EVENT;
        end
        event_d = event_d | event_set;
    end

    // mask next value
    always @* begin
        mask_d = mask_q;
        if (do_write && wlane_q && wsel == SEL_MASK) begin
            mask_d = wbyte_q[`PSCR_EV_W-1:0];
        end
    end

    // write address and data capture, then response
    always @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_awready <= 1'b1;
            o_wready <= 1'b1;
            o_bvalid <= 1'b0;
            o_bresp <= `PSCR_RESP_OKAY;
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= 8'h00;
            wbyte_q <= 8'h00;
            wlane_q <= 1'b0;
        end else begin
            if (aw_take) begin
                o_awready <= 1'b0;
                aw_full_q <= 1'b1;
                awaddr_q <= i_awaddr;
            end
            if (w_take) begin
                o_wready <= 1'b0;
                w_full_q <= 1'b1;
                wbyte_q <= i_wdata[7:0];
                wlane_q <= i_wstrb[0];
            end
            if (do_write) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= (wsel == SEL_NONE) ? `PSCR_RESP_DECERR : `PSCR_RESP_OKAY;
            end
            if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
                o_awready <= 1'b1;
                o_wready <= 1'b1;
            end
        end
    end

    // control register; status is never written
    always @(posedge i_mclk) begin
        if (!i_resetn) begin
            arm_q <= 1'b0;
            go_q <= 1'b0;
        end else begin
            go_q <= 1'b0;
            if (do_write && wlane_q && wsel == SEL_CONTROL) begin
                arm_q <= wbyte_q[`PSCR_CT_ARM];
                go_q <= wbyte_q[`PSCR_CT_GO];
            end
        end
    end

    // measurement start pulse and captured band
    always @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_cell_measure_start <= 1'b0;
            cell_band_q <= `PSCR_RST_CELL;
        end else begin
            o_cell_measure_start <= go_q;
            if (i_cell_done) begin
                cell_band_q <= i_cell_band;
            end
        end
    end

    // shutdown request and edge history
    always @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_powerfail_shutdown <= 1'b0;
            trip_prev_q <= 1'b0;
            pins_prev_q <= `PSCR_RST_PINS;
        end else begin
            o_powerfail_shutdown <= trip;
            trip_prev_q <= trip;
            pins_prev_q <= pins_s;
        end
    end

    // event, mask and interrupt
    always @(posedge i_mclk) begin
        if (!i_resetn) begin
            event_q <= `PSCR_RST_EVENT;
            mask_q <= `PSCR_RST_MASK;
            o_irq <= 1'b0;
        end else begin
            event_q <= event_d;
            mask_q <= mask_d;
            o_irq <= |(event_d & mask_d);
        end
    end

    // read channel, data one cycle after the address is taken
    always @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_arready <= 1'b1;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h00000000;
            o_rresp <= `PSCR_RESP_OKAY;
        end else begin
            if (ar_take) begin
                o_arready <= 1'b0;
                o_rvalid <= 1'b1;
                o_rdata <= {24'h000000, read_byte};
                o_rresp <= (rsel == SEL_NONE) ? `PSCR_RESP_DECERR : `PSCR_RESP_OKAY;
            end
            if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
                o_arready <= 1'b1;
            end
        end
    end

endmodule

// file: testbench/pscr_regs_sva.sv
// Purpose: concurrent checks on the status/control register bank ports
// Assumes: byte addresses status 0x14, control 0x18
// Notes: helpers remember the last accepted addresses and the measured band
`timescale 1ns/1ps
module pscr_regs_chk (
    input wire i_mclk,
    input wire i_resetn,
    input wire i_arvalid,
    input wire o_arready,
    input wire o_rvalid,
    input wire i_awvalid,
    input wire o_awready,
    input wire i_wvalid,
    input wire o_wready,
    input wire o_bvalid,
    input wire i_adapter_detect_pin,
    input wire i_push_button_pin,
    input wire i_powerfail_out_n,
    input wire i_factory_seal_broken,
    input wire i_nv_settings_modified,
    input wire i_cell_done,
    input wire o_cell_measure_start,
    input wire o_powerfail_shutdown,
    input wire [7:0] i_araddr,
    input wire [7:0] i_awaddr,
    input wire [31:0] o_rdata,
    input wire [31:0] i_wdata,
    input wire [3:0] i_wstrb,
    input wire [1:0] i_power_state,
    input wire [1:0] i_cell_band
);
    reg rv_q, bv_q, wd_q;
    reg [7:0] ra_q, wa_q;
    reg [1:0] bq_q;
    // first cycle of a status read, a control read, a go write
    wire sr = o_rvalid && !rv_q && ra_q == 8'h14;
    wire cr = o_rvalid && !rv_q && ra_q == 8'h18;
    wire gw = o_bvalid && !bv_q && wa_q == 8'h18 && wd_q;
    // capture accepted addresses, write bit 0 and measured band
    always @(posedge i_mclk) begin
        rv_q <= o_rvalid;
        bv_q <= o_bvalid;
        if (i_arvalid && o_arready) ra_q <= i_araddr;
        if (i_awvalid && o_awready) wa_q <= i_awaddr;
        if (i_wvalid && o_wready) wd_q <= i_wdata[0] & i_wstrb[0];
        if (!i_resetn) bq_q <= 2'h0;
        else if (i_cell_done) bq_q <= i_cell_band;
    end
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);
    chk_seal_show: assert property (sr |-> o_rdata[7] == $past(i_factory_seal_broken))
        else $error("seal bit wrong");
    chk_nvmod_show: assert property (sr |-> o_rdata[6] == $past(i_nv_settings_modified))
        else $error("nv bit wrong");
    chk_adapter_inv: assert property (sr && $past(i_resetn, 3) &&
        $past(i_adapter_detect_pin, 3) == $past(i_adapter_detect_pin) && $past(i_adapter_detect_pin, 2) ==
        $past(i_adapter_detect_pin) |-> o_rdata[5] == !$past(i_adapter_detect_pin)) else $error("adapter bit wrong");
    chk_button_inv: assert property (sr && $past(i_resetn, 3) &&
        $past(i_push_button_pin, 3) == $past(i_push_button_pin) && $past(i_push_button_pin, 2) ==
        $past(i_push_button_pin) |-> o_rdata[4] == !$past(i_push_button_pin)) else $error("button bit wrong");
    chk_state_show: assert property (sr |-> o_rdata[3:2] == $past(i_power_state))
        else $error("state field wrong");
    chk_band_show: assert property (sr |-> o_rdata[1:0] == $past(bq_q))
        else $error("band field wrong");
    chk_fail_cause: assert property (o_powerfail_shutdown |-> !$past(i_powerfail_out_n, 3))
        else $error("shutdown without trip");
    chk_go_pulse: assert property (gw |=> o_cell_measure_start ##1 !o_cell_measure_start)
        else $error("start pulse wrong");
    chk_ctl_upper: assert property (cr |-> o_rdata[31:2] == 30'h0)
        else $error("control upper bits set");
    chk_reset_idle: assert property ($rose(i_resetn) |-> !o_cell_measure_start && !o_powerfail_shutdown)
        else $error("outputs busy after reset");
endmodule
bind pscr_regs pscr_regs_chk u_chk (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_arvalid(i_arvalid),
    .o_arready(o_arready),
    .o_rvalid(o_rvalid),
    .i_awvalid(i_awvalid),
    .o_awready(o_awready),
    .i_wvalid(i_wvalid),
    .o_wready(o_wready),
    .o_bvalid(o_bvalid),
    .i_adapter_detect_pin(i_adapter_detect_pin),
    .i_push_button_pin(i_push_button_pin),
    .i_powerfail_out_n(i_powerfail_out_n),
    .i_factory_seal_broken(i_factory_seal_broken),
    .i_nv_settings_modified(i_nv_settings_modified),
    .i_cell_done(i_cell_done),
    .o_cell_measure_start(o_cell_measure_start),
    .o_powerfail_shutdown(o_powerfail_shutdown),
    .i_araddr(i_araddr),
    .i_awaddr(i_awaddr),
    .o_rdata(o_rdata),
    .i_wdata(i_wdata),
    .i_wstrb(i_wstrb),
    .i_power_state(i_power_state),
    .i_cell_band(i_cell_band)
);

// file: testbench/pscr_regs_tb.sv
// Purpose: self-checking bench of the register bank over axi4-lite
// Assumes: 10 MHz clock, status 0x14, control 0x18, event 0x20, mask 0x24
// Notes: protection is tied; one write drops byte lane 0; a cycle ceiling cuts hangs
`timescale 1ns/1ps
module pscr_regs_tb;
    reg i_mclk = 0, i_resetn = 0, i_awvalid = 0, i_wvalid = 0, i_bready = 0;
    reg i_arvalid = 0, i_rready = 0, i_cell_done = 0;
    reg i_adapter_detect_pin = 1, i_push_button_pin = 1, i_powerfail_out_n = 1;
    reg i_factory_seal_broken = 0, i_nv_settings_modified = 0;
    reg [7:0] i_awaddr = 0, i_araddr = 0;
    reg [31:0] i_wdata = 0;
    reg [1:0] i_power_state = 0, i_cell_band = 0;
    wire [2:0] i_awprot = 3'h0, i_arprot = 3'h0;
    reg [3:0] i_wstrb = 4'hf;
    wire o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
    wire o_cell_measure_start, o_powerfail_shutdown;
    wire [1:0] o_bresp, o_rresp;
    wire [31:0] o_rdata;
    integer err_total = 0, compares = 0, cyc = 0, starts = 0, i;
    pscr_regs dut (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_awvalid(i_awvalid),
        .o_awready(o_awready),
        .i_awaddr(i_awaddr),
        .i_awprot(i_awprot),
        .i_wvalid(i_wvalid),
        .o_wready(o_wready),
        .i_wdata(i_wdata),
        .i_wstrb(i_wstrb),
        .o_bvalid(o_bvalid),
        .i_bready(i_bready),
        .o_bresp(o_bresp),
        .i_arvalid(i_arvalid),
        .o_arready(o_arready),
        .i_araddr(i_araddr),
        .i_arprot(i_arprot),
        .o_rvalid(o_rvalid),
        .i_rready(i_rready),
        .o_rdata(o_rdata),
        .o_rresp(o_rresp),
        .i_adapter_detect_pin(i_adapter_detect_pin),
        .i_push_button_pin(i_push_button_pin),
        .i_powerfail_out_n(i_powerfail_out_n),
        .i_factory_seal_broken(i_factory_seal_broken),
        .i_nv_settings_modified(i_nv_settings_modified),
        .i_power_state(i_power_state),
        .i_cell_done(i_cell_done),
        .i_cell_band(i_cell_band),
        .o_cell_measure_start(o_cell_measure_start),
        .o_powerfail_shutdown(o_powerfail_shutdown),
        .o_irq(o_irq)
    );
    always #50 i_mclk = ~i_mclk;
    // count start pulses and stop a hung run
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (o_cell_measure_start === 1'b1) starts <= starts + 1;
        if (cyc == 4000) begin
            err_total = err_total + 1;
            summarize;
        end
    end
    task chk(input string n, input [31:0] s, input [31:0] e);
        compares = compares + 1;
        if (s !== e) begin
            err_total = err_total + 1;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task summarize;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task wr(input [7:0] a, input [31:0] d, input [1:0] r);
        @(posedge i_mclk);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1;
        i_wvalid <= 1;
        i_bready <= 1;
        do begin
            @(posedge i_mclk);
            if (o_awready) i_awvalid <= 0;
            if (o_wready) i_wvalid <= 0;
        end while (o_bvalid !== 1'b1);
        i_bready <= 0;
        chk("bresp", o_bresp, r);
    endtask
    task rd(input [7:0] a, input [31:0] e, input [1:0] r, input string n);
        @(posedge i_mclk);
        i_araddr <= a;
        i_arvalid <= 1;
        i_rready <= 1;
        do begin
            @(posedge i_mclk);
            if (o_arready) i_arvalid <= 0;
        end while (o_rvalid !== 1'b1);
        i_rready <= 0;
        if (n != "") begin
            chk(n, o_rdata, e);
            chk("rresp", o_rresp, r);
        end
    endtask
    task pulse(input [1:0] b);
        @(posedge i_mclk);
        i_cell_band <= b;
        i_cell_done <= 1;
        @(posedge i_mclk);
        i_cell_done <= 0;
    endtask
    // main sequence
    initial begin
        repeat (5) @(posedge i_mclk);
        i_resetn <= 1;
        rd(8'h18, 32'h0, 2'h0, "control");
        rd(8'h14, 32'h0, 2'h0, "status");
        $display("reset test done");
        for (i = 0; i < 4; i = i + 1) begin
            i_factory_seal_broken <= i[0];
            i_nv_settings_modified <= i[1];
            i_adapter_detect_pin <= i[0];
            i_push_button_pin <= i[1];
            i_power_state <= i[1:0];
            pulse(i[1:0]);
            repeat (3) @(posedge i_mclk);
            rd(8'h14, {i[0], i[1], ~i[0], ~i[1], i[1:0], i[1:0]}, 2'h0, "status");
        end
        $display("status test done");
        wr(8'h18, 32'hff, 2'h0);
        repeat (2) @(posedge i_mclk);
        chk("starts", starts, 1);
        rd(8'h18, 32'h2, 2'h0, "control");
        wr(8'h14, 32'h0, 2'h0);
        rd(8'h14, 32'hcf, 2'h0, "status");
        wr(8'h40, 32'hff, 2'h3);
        rd(8'h40, 32'h0, 2'h3, "unmapped");
        $display("control test done");
        i_powerfail_out_n <= 0;
        repeat (4) @(posedge i_mclk);
        chk("shutdown", o_powerfail_shutdown, 1);
        wr(8'h18, 32'h0, 2'h0);
        repeat (2) @(posedge i_mclk);
        chk("shutdown", o_powerfail_shutdown, 0);
        chk("starts", starts, 1);
        i_powerfail_out_n <= 1;
        i_wstrb <= 4'he;
        wr(8'h18, 32'h2, 2'h0);
        i_wstrb <= 4'hf;
        rd(8'h18, 32'h0, 2'h0, "control");
        $display("shutdown test done");
        rd(8'h20, 32'hf, 2'h0, "event");
        wr(8'h24, 32'h4, 2'h0);
        pulse(2'h1);
        repeat (3) @(posedge i_mclk);
        chk("irq", o_irq, 1);
        rd(8'h20, 32'h4, 2'h0, "event");
        repeat (2) @(posedge i_mclk);
        chk("irq", o_irq, 0);
        rd(8'h20, 32'h0, 2'h0, "event");
        rd(8'h24, 32'h4, 2'h0, "mask");
        wr(8'h24, 32'h0, 2'h0);
        pulse(2'h2);
        repeat (3) @(posedge i_mclk);
        chk("irq", o_irq, 0);
        rd(8'h20, 32'h4, 2'h0, "event");
        i_adapter_detect_pin <= 0;
        i_push_button_pin <= 0;
        repeat (4) @(posedge i_mclk);
        rd(8'h20, 32'h3, 2'h0, "event");
        $display("irq test done");
        summarize;
    end
endmodule
